// ### core/sist_top.sv
// Short-circuit test, debounce, pairing and passivation of a 16-channel safe input
`timescale 1ns/100ps
`default_nettype none
`include "sist_regs.svh"
module sist_top #(
	parameter int TICK_CYCLES = `SIST_TICK_CYC
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [7:0] addr,
	input wire logic [31:0] wrData,
	input wire logic wrEn,
	input wire logic rdEn,
	output logic [31:0] rdData,
	input wire logic [15:0] rawIn,
	output logic sensorSupplyA,
	output logic sensorSupplyB,
	output logic [15:0] pvOut,
	output logic [15:0] passivated,
	output logic irq
);
	sist_tb_if tb ();

	logic sctEn_r;
	logic [2:0] intSel_r;
	logic [1:0] durSel_r;
	sist_pkg::sist_ch_t active_r;
	sist_pkg::sist_ch_t ackMode_r;
	sist_pkg::sist_ch_t supplyInt_r;
	sist_pkg::sist_pair_t pair_r;
	logic [14:0] discMs_r;
	logic [47:0] fltSel_r;
	logic [16:0] stat_r;
	logic [16:0] mask_r;
	sist_pkg::sist_ch_t sctFail_r;
	sist_pkg::sist_pair_t discErr_r;
	sist_pkg::sist_ch_t cond;
	sist_pkg::sist_ch_t ackPulse;
	sist_pkg::sist_ch_t pvNxt;
	sist_pkg::sist_ch_t filt;
	sist_pkg::sist_ch_t newFault;
	logic [18:0] discLim;
	logic cfgWr;
	logic cfgOk;
	logic [16:0] intReq;
	logic [16:0] durReq;

	assign tb.sctEn = sctEn_r;
	assign tb.intSel = intSel_r;
	assign tb.durSel = durSel_r;

	sist_timebase #(
		.TICK_CYCLES(TICK_CYCLES)
	) u_timebase (
		.clk(clk),
		.nrst(nrst),
		.tb(tb.gen)
	);

	sist_debounce u_debounce (
		.clk(clk),
		.nrst(nrst),
		.tb(tb.filt),
		.rawIn(rawIn),
		.freeze(supplyInt_r & active_r & {16{tb.testOn}}),
		.fltSel(fltSel_r),
		.filt(filt)
	);

	// Ratio check of a control write, in ticks
	assign cfgWr = wrEn && (addr == `SIST_ADR_CTRL);
	assign intReq = 17'(`SIST_INT_BASE) << wrData[`SIST_CTRL_INT_LSB +: 3];
	assign durReq = 17'(`SIST_DUR_BASE) << wrData[`SIST_CTRL_DUR_LSB +: 2];
	assign cfgOk = (wrData[`SIST_CTRL_INT_LSB +: 3] <= `SIST_INT_SEL_MAX)
		&& (intReq >= `SIST_SCT_RATIO * durReq); // RQ7

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sctEn_r <= `SIST_RST_EN; // RQ4
			intSel_r <= `SIST_RST_INT; // RQ5
			durSel_r <= `SIST_RST_DUR; // RQ6
		end else if (cfgWr && cfgOk) begin
			sctEn_r <= wrData[`SIST_CTRL_EN];
			intSel_r <= wrData[`SIST_CTRL_INT_LSB +: 3];
			durSel_r <= wrData[`SIST_CTRL_DUR_LSB +: 2];
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			active_r <= `SIST_RST_ACT; // RQ8
			ackMode_r <= `SIST_RST_ACKMODE; // RQ11
			supplyInt_r <= `SIST_RST_SUPPLY; // RQ12
			pair_r <= `SIST_RST_PAIR; // RQ13
			discMs_r <= `SIST_RST_DISC;
			fltSel_r <= {16{`SIST_RST_FLT}}; // RQ10
			mask_r <= 17'h00000;
		end else if (wrEn) begin
			case (addr)
				`SIST_ADR_ACT: active_r <= wrData[15:0];
				`SIST_ADR_ACKMODE: ackMode_r <= wrData[15:0];
				`SIST_ADR_SUPPLY: supplyInt_r <= wrData[15:0];
				`SIST_ADR_PAIR: pair_r <= wrData[7:0];
				`SIST_ADR_DISC: discMs_r <= wrData[14:0];
				`SIST_ADR_FLT_LO: fltSel_r[23:0] <= wrData[23:0];
				`SIST_ADR_FLT_HI: fltSel_r[47:24] <= wrData[23:0];
				`SIST_ADR_MASK: mask_r <= wrData[16:0];
				default: begin
				end
			endcase
		end
	end

	assign ackPulse = (wrEn && addr == `SIST_ADR_ACK) ? wrData[15:0] : 16'h0000;
	assign discLim = 19'(discMs_r) * 19'(`SIST_MS_TICKS);

	genvar i;
	generate
		for (i = 0; i < 16; i++) begin : g_ch
			// Only active, internally supplied channels are judged by the pulse
			always_ff @(posedge clk or negedge nrst) begin
				if (!nrst) begin
					sctFail_r[i] <= 1'b0;
				end else if (!active_r[i] || !supplyInt_r[i]) begin
					sctFail_r[i] <= 1'b0; // RQ8 RQ12
				end else if (tb.testEnd) begin
					sctFail_r[i] <= rawIn[i]; // RQ1 RQ2
				end
			end

			if (i < 8) begin : g_lo
				logic [18:0] discCnt_r;
				always_ff @(posedge clk or negedge nrst) begin
					if (!nrst) begin
						discCnt_r <= 19'h00000;
						discErr_r[i] <= 1'b0;
					end else if (!pair_r[i] || !active_r[i] || !active_r[i+8]) begin
						discCnt_r <= 19'h00000; // RQ9
						discErr_r[i] <= 1'b0;
					end else if (filt[i] == filt[i+8]) begin
						discCnt_r <= 19'h00000;
						discErr_r[i] <= 1'b0;
					end else if (tb.tick && discCnt_r < discLim) begin
						discCnt_r <= discCnt_r + 19'h00001;
					end else if (discCnt_r >= discLim) begin
						discErr_r[i] <= 1'b1; // RQ16
					end
				end
				assign cond[i] = sctFail_r[i] | discErr_r[i];
				// Equivalent pair, disagreement reports zero
				assign pvNxt[i] = pair_r[i] ? (filt[i] & filt[i+8]) : filt[i]; // RQ15
			end else begin : g_hi
				assign cond[i] = sctFail_r[i];
				assign pvNxt[i] = pair_r[i-8] ? 1'b0 : filt[i]; // RQ13
			end

			always_ff @(posedge clk or negedge nrst) begin
				if (!nrst) begin
					passivated[i] <= 1'b0;
				end else if (!active_r[i]) begin
					passivated[i] <= 1'b0; // RQ8
				end else if (cond[i]) begin
					passivated[i] <= 1'b1; // RQ2 RQ16
				end else if (!ackMode_r[i] || ackPulse[i]) begin
					passivated[i] <= 1'b0; // RQ11
				end
			end

			// Pulse holds the value, so a real zero shows only after it ends
			always_ff @(posedge clk or negedge nrst) begin
				if (!nrst) begin
					pvOut[i] <= 1'b0;
				end else if (!active_r[i] || passivated[i] || cond[i]) begin
					pvOut[i] <= 1'b0; // RQ18 RQ16
				end else if (!tb.testOn) begin
					pvOut[i] <= pvNxt[i]; // RQ3
				end
			end
		end
	endgenerate

	// Supplies are driven from flops, off during the pulse
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sensorSupplyA <= 1'b1;
			sensorSupplyB <= 1'b1;
		end else begin
			sensorSupplyA <= !tb.testOn; // RQ1
			sensorSupplyB <= !tb.testOn; // RQ1
		end
	end

	assign newFault = cond & active_r & ~passivated;

	// New events win over a clear in the same cycle
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			stat_r <= 17'h00000;
		end else begin
			stat_r <= (stat_r & ~((wrEn && addr == `SIST_ADR_STAT) ? wrData[16:0] : 17'h00000))
				| {cfgWr && !cfgOk, newFault};
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(stat_r & mask_r);
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rdData <= 32'h00000000;
		end else if (!rdEn) begin
			rdData <= 32'h00000000;
		end else begin
			case (addr)
				`SIST_ADR_CTRL: rdData <= {26'h0, durSel_r, intSel_r, sctEn_r};
				`SIST_ADR_ACT: rdData <= {16'h0, active_r};
				`SIST_ADR_ACKMODE: rdData <= {16'h0, ackMode_r};
				`SIST_ADR_SUPPLY: rdData <= {16'h0, supplyInt_r};
				`SIST_ADR_PAIR: rdData <= {24'h0, pair_r};
				`SIST_ADR_DISC: rdData <= {17'h0, discMs_r};
				`SIST_ADR_FLT_LO: rdData <= {8'h0, fltSel_r[23:0]};
				`SIST_ADR_FLT_HI: rdData <= {8'h0, fltSel_r[47:24]};
				`SIST_ADR_PV: rdData <= {16'h0, pvOut};
				`SIST_ADR_FAULT: rdData <= {16'h0, passivated};
				`SIST_ADR_STAT: rdData <= {15'h0, stat_r};
				`SIST_ADR_MASK: rdData <= {15'h0, mask_r};
				default: rdData <= 32'h00000000;
			endcase
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	a_hold_during_pulse: assert property (tb.testOn && !(|cond) && (&active_r)
		&& !(|passivated) |=> pvOut == $past(pvOut)) // RQ3
		else $error("process value moved during pulse");
	a_sct_fail_pass: assert property (tb.testEnd && rawIn[0] && active_r[0] && supplyInt_r[0]
		|=> ##1 passivated[0]) // RQ2
		else $error("short not passivated");
	a_ext_no_test: assert property (!supplyInt_r[3] |=> !sctFail_r[3]) // RQ12
		else $error("test on external channel");
	a_inactive_quiet: assert property (!active_r[5] |=> !pvOut[5] && !passivated[5]) // RQ8
		else $error("inactive channel not quiet");
	a_cfg_ratio_ok: assert property (intSel_r >= {1'b0, durSel_r} && intSel_r <= 3'h6) // RQ7
		else $error("timing ratio broken");
	a_pair_upper_zero: assert property (pair_r[2] && !tb.testOn |=> !pvOut[10]) // RQ15
		else $error("upper pair channel reported");
	a_passive_zero: assert property (passivated[6] |=> !pvOut[6]) // RQ18
		else $error("passivated channel reported one");
	a_manual_ack_hold: assert property (passivated[1] && ackMode_r[1] && active_r[1]
		&& !ackPulse[1] |=> passivated[1]) // RQ11
		else $error("manual channel left passive without ack");
	a_disc_passivate: assert property (discErr_r[0] && active_r[0] |=> passivated[0]) // RQ16
		else $error("discrepancy not passivated");
	a_supply_off: assert property (tb.testOn |=> !sensorSupplyA && !sensorSupplyB) // RQ1
		else $error("supply not off in pulse");
	c_sct_fail: cover property (tb.testEnd && rawIn[0] && supplyInt_r[0]);
	c_ack_reint: cover property (passivated[1] ##1 !passivated[1]);
	c_disc_err: cover property (discErr_r[0]);
endmodule // sist_top
`default_nettype wire

// ### core/sist_regs.svh
// Register offsets, reset values and timing constants of the short-test block
// Notes on behaviour
// RQ1 - With the test enabled, supplies pulse off periodically; powered inputs must read zero.
// RQ2 - A channel reading one during its supply off pulse is faulty and passivated.
// RQ3 - Process value is frozen during a pulse; zeros pass only after the pulse.
// RQ4 - Short-circuit test is off after reset until software enables it.
// RQ5 - Pulse spacing 12.8 to 819.2 ms in powers of two, default 25.6 ms.
// RQ6 - Pulse length 1.6, 3.2, 6.4 or 12.8 ms, default 1.6 ms.
// RQ7 - Spacing must be at least eight times length; violating writes are refused.
// RQ8 - Channels active by default; an inactive channel has no diagnostics.
// RQ9 - Software pairs only active channels and unpairs before changing activation.
// RQ10 - Each input is debounced for 0.8 to 12.8 ms, default 6.4 ms.
// RQ11 - Cleared faults reintegrate automatically or after acknowledge; acknowledge by default.
// RQ12 - Supply per channel internal or external, default external; external skips the test.
// RQ13 - Channel x runs alone or paired with x+8; single by default.
// RQ14 - Software sets connection type and discrepancy time for a pair; only the discrepancy time is settable here, pairs are always equivalent.
// RQ15 - A pair reports its result at the lower channel position.
// RQ16 - Pair disagreement beyond the discrepancy time passivates and forces zero.
// RQ17 - All timing comes from one free-running 0.1 ms timebase.
// RQ18 - Passivated channels report zero until reintegration is allowed.
`ifndef SIST_REGS_SVH
`define SIST_REGS_SVH

`define SIST_CLK_MHZ 200
`define SIST_TICK_US 100
`define SIST_TICK_CYC (`SIST_TICK_US * `SIST_CLK_MHZ)
`define SIST_INT_BASE_US 12800
`define SIST_DUR_BASE_US 1600
`define SIST_FLT_BASE_US 800
`define SIST_INT_BASE 14'(`SIST_INT_BASE_US / `SIST_TICK_US)
`define SIST_DUR_BASE 14'(`SIST_DUR_BASE_US / `SIST_TICK_US)
`define SIST_FLT_BASE 8'(`SIST_FLT_BASE_US / `SIST_TICK_US)
`define SIST_SCT_RATIO 17'h8
`define SIST_INT_SEL_MAX 3'h6
`define SIST_FLT_SEL_MAX 3'h4
`define SIST_MS_TICKS 4'hA

`define SIST_ADR_CTRL 8'h00
`define SIST_ADR_ACT 8'h04
`define SIST_ADR_ACKMODE 8'h08
`define SIST_ADR_SUPPLY 8'h0C
`define SIST_ADR_PAIR 8'h10
`define SIST_ADR_DISC 8'h14
`define SIST_ADR_FLT_LO 8'h18
`define SIST_ADR_FLT_HI 8'h1C
`define SIST_ADR_ACK 8'h20
`define SIST_ADR_PV 8'h24
`define SIST_ADR_FAULT 8'h28
`define SIST_ADR_STAT 8'h2C
`define SIST_ADR_MASK 8'h30

`define SIST_CTRL_EN 0
`define SIST_CTRL_INT_LSB 1
`define SIST_CTRL_DUR_LSB 4
`define SIST_STAT_CFGERR 16

`define SIST_RST_EN 1'h0
`define SIST_RST_INT 3'h1
`define SIST_RST_DUR 2'h0
`define SIST_RST_ACT 16'hFFFF
`define SIST_RST_ACKMODE 16'hFFFF
`define SIST_RST_SUPPLY 16'h0000
`define SIST_RST_PAIR 8'h00
`define SIST_RST_DISC 15'h000A
`define SIST_RST_FLT 3'h3

`endif

// ### core/sist_pkg.sv
// Types shared by the short-test block
package sist_pkg;
	typedef logic [15:0] sist_ch_t;
	typedef logic [7:0] sist_pair_t;
	typedef logic [13:0] sist_ticks_t;
	typedef enum logic [1:0] {
		SIST_ST_IDLE = 2'b00,
		SIST_ST_TEST = 2'b01,
		SIST_ST_RUN = 2'b10
	} sist_state_t;
endpackage

// ### core/sist_tb_if.sv
// Timebase and test pulse signals shared inside the block
`timescale 1ns/100ps
`default_nettype none
interface sist_tb_if;
	logic tick;
	logic testOn;
	logic testEnd;
	logic sctEn;
	logic [2:0] intSel;
	logic [1:0] durSel;
	modport gen (input sctEn, input intSel, input durSel, output tick, output testOn,
		output testEnd);
	modport cfg (output sctEn, output intSel, output durSel, input tick, input testOn,
		input testEnd);
	modport filt (input tick);
endinterface
`default_nettype wire

// ### core/sist_timebase.sv
// Free-running tick and supply off pulse scheduler
`timescale 1ns/100ps
`default_nettype none
`include "sist_regs.svh"
module sist_timebase #(
	parameter int TICK_CYCLES = `SIST_TICK_CYC
) (
	input wire logic clk,
	input wire logic nrst,
	sist_tb_if.gen tb
);
	logic [14:0] tickCnt_r;
	logic tick;
	sist_pkg::sist_state_t state_r;
	sist_pkg::sist_ticks_t phase_r;
	sist_pkg::sist_ticks_t intT;
	sist_pkg::sist_ticks_t durT;

	assign intT = `SIST_INT_BASE << tb.intSel; // RQ5
	assign durT = `SIST_DUR_BASE << tb.durSel; // RQ6
	assign tick = (tickCnt_r == 15'(TICK_CYCLES - 1));

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			tickCnt_r <= 15'h0000;
		end else begin
			tickCnt_r <= tick ? 15'h0000 : tickCnt_r + 15'h0001; // RQ17
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_r <= sist_pkg::SIST_ST_IDLE;
			phase_r <= 14'h0000;
		end else begin
			case (state_r)
				sist_pkg::SIST_ST_IDLE: begin
					phase_r <= 14'h0000;
					// Start on a tick so the pulse is a whole number of ticks
					if (tb.sctEn && tick) begin
						state_r <= sist_pkg::SIST_ST_TEST; // RQ1
					end
				end
				sist_pkg::SIST_ST_TEST: begin
					if (tick) begin
						phase_r <= phase_r + 14'h0001;
						if (phase_r == durT - 14'h0001) begin
							state_r <= tb.sctEn ? sist_pkg::SIST_ST_RUN : sist_pkg::SIST_ST_IDLE;
						end
					end
				end
				sist_pkg::SIST_ST_RUN: begin
					if (!tb.sctEn) begin
						state_r <= sist_pkg::SIST_ST_IDLE; // RQ4
					end else if (tick) begin
						if (phase_r == intT - 14'h0001) begin
							phase_r <= 14'h0000;
							state_r <= sist_pkg::SIST_ST_TEST; // RQ5
						end else begin
							phase_r <= phase_r + 14'h0001;
						end
					end
				end
				default: begin
					state_r <= sist_pkg::SIST_ST_IDLE;
				end
			endcase
		end
	end

	assign tb.tick = tick;
	assign tb.testOn = (state_r == sist_pkg::SIST_ST_TEST);
	assign tb.testEnd = tb.testOn && tick && (phase_r == durT - 14'h0001);

	// Ticks seen during the current pulse, for checking only
	sist_pkg::sist_ticks_t hTicks_r;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			hTicks_r <= 14'h0000;
		end else if (!tb.testOn) begin
			hTicks_r <= 14'h0000;
		end else if (tick) begin
			hTicks_r <= hTicks_r + 14'h0001;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	a_pulse_length: assert property (tb.testEnd |-> hTicks_r == durT - 14'h0001) // RQ6
		else $error("test pulse length wrong");
	a_test_disabled: assert property (!tb.sctEn && !tb.testOn |=> !tb.testOn) // RQ4
		else $error("pulse started while test disabled");
	c_pulse_end: cover property (tb.testEnd);
endmodule // sist_timebase
`default_nettype wire

// ### core/sist_debounce.sv
// Per-channel input debounce filters
`timescale 1ns/100ps
`default_nettype none
`include "sist_regs.svh"
module sist_debounce (
	input wire logic clk,
	input wire logic nrst,
	sist_tb_if.filt tb,
	input wire logic [15:0] rawIn,
	input wire logic [15:0] freeze,
	input wire logic [47:0] fltSel,
	output logic [15:0] filt
);
	function automatic logic [7:0] fltTicks(input logic [2:0] sel);
		logic [2:0] s;
		s = (sel > `SIST_FLT_SEL_MAX) ? `SIST_FLT_SEL_MAX : sel;
		return `SIST_FLT_BASE << s;
	endfunction

	genvar i;
	generate
		for (i = 0; i < 16; i++) begin : g_ch
			logic [7:0] cnt_r;
			logic [7:0] lim;
			assign lim = fltTicks(fltSel[3*i +: 3]);
			always_ff @(posedge clk or negedge nrst) begin
				if (!nrst) begin
					cnt_r <= 8'h00;
					filt[i] <= 1'b0;
				end else if (freeze[i]) begin
					cnt_r <= cnt_r; // RQ3
				end else if (rawIn[i] == filt[i]) begin
					cnt_r <= 8'h00;
				end else if (tb.tick) begin
					if (cnt_r >= lim - 8'h01) begin
						filt[i] <= rawIn[i]; // RQ10
						cnt_r <= 8'h00;
					end else begin
						cnt_r <= cnt_r + 8'h01;
					end
				end
			end
		end
	endgenerate

	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	a_filter_hold: assert property (!tb.tick |=> $stable(filt)) // RQ10
		else $error("filtered input changed without a tick");
endmodule // sist_debounce
`default_nettype wire

// ### sim/sist_sensor_model.sv
// Model of the sensors and wiring on the raw input side
`timescale 1ns/100ps
`default_nettype none
module sist_sensor_model (
	input wire logic sensorSupplyA,
	input wire logic sensorSupplyB,
	input wire logic [15:0] want,
	input wire logic [15:0] shortCh,
	input wire logic [15:0] internalCh,
	output logic [15:0] rawIn
);
	logic supOk;
	// A short to a power source keeps the input high whatever the supply does
	always_comb begin
		rawIn = 16'h0000;
		for (int i = 0; i < 16; i++) begin
			supOk = (i < 8) ? sensorSupplyA : sensorSupplyB;
			rawIn[i] = shortCh[i] | (want[i] & (!internalCh[i] | supOk));
		end
	end
endmodule // sist_sensor_model
`default_nettype wire

// ### sim/tb_top.sv
// Self-checking bench for the short-test block
`timescale 1ns/100ps
`default_nettype none
`include "sist_regs.svh"
module tb_top;
	localparam int TC = 4;
	logic clk = 1'h0;
	logic nrst = 1'h0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wrData = 32'h0;
	logic wrEn = 1'h0;
	logic rdEn = 1'h0;
	logic [31:0] rdData;
	logic [15:0] rawIn;
	logic [15:0] pvOut;
	logic [15:0] passivated;
	logic sensorSupplyA;
	logic sensorSupplyB;
	logic irq;
	logic [15:0] want = 16'h0000;
	logic [15:0] shortCh = 16'h0000;
	logic [15:0] internalCh = 16'h0000;
	logic supPrev = 1'h1;
	logic [15:0] pvPrev = 16'h0000;
	int miscompares = 0;
	int total_checks = 0;
	int freezeErr = 0;

	always #2.5 clk = ~clk;

	sist_top #(.TICK_CYCLES(TC)) u_dut (.clk(clk), .nrst(nrst), .addr(addr), .wrData(wrData),
		.wrEn(wrEn), .rdEn(rdEn), .rdData(rdData), .rawIn(rawIn),
		.sensorSupplyA(sensorSupplyA), .sensorSupplyB(sensorSupplyB), .pvOut(pvOut),
		.passivated(passivated), .irq(irq));
	sist_sensor_model u_sensors (.sensorSupplyA(sensorSupplyA),
		.sensorSupplyB(sensorSupplyB), .want(want), .shortCh(shortCh),
		.internalCh(internalCh), .rawIn(rawIn));

	// Any change of the reported values while the supply stays off is a fault
	always @(posedge clk) begin
		if (!supPrev && !sensorSupplyA && pvOut !== pvPrev) freezeErr++;
		supPrev <= sensorSupplyA;
		pvPrev <= pvOut;
	end

	task automatic final_report();
		$display("Checks %0d, mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("Error at %0t: %s got %h expected %h", $time, msg, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wrData <= d;
		wrEn <= 1'h1;
		@(posedge clk);
		wrEn <= 1'h0;
	endtask

	task automatic rdChk(input logic [7:0] a, input logic [31:0] exp, input string msg);
		@(posedge clk);
		addr <= a;
		rdEn <= 1'h1;
		@(posedge clk);
		rdEn <= 1'h0;
		#1 chk(rdData, exp, msg);
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// Bounded wait for a supply level; n counts the edges it took
	task automatic waitSup(input logic lvl, output int n);
		n = 0;
		while (sensorSupplyA !== lvl) begin
			@(posedge clk);
			#1;
			n++;
			if (n > 3000) begin
				miscompares++;
				$display("Error at %0t: supply level wait ran out", $time);
				final_report();
			end
		end
	endtask

	function automatic logic [31:0] ctrlVal(input int i, input int d);
		return 32'((d << 4) | (i << 1));
	endfunction

	initial begin
		int n;
		int w;
		int g;
		int ft;
		logic [31:0] ctl;
		logic seen;
		void'($urandom(55));
		repeat (6) @(posedge clk);
		nrst <= 1'h1;
		rdChk(`SIST_ADR_CTRL, 32'h00000002, "ctrl reset");
		rdChk(`SIST_ADR_ACT, 32'h0000FFFF, "active reset");
		rdChk(`SIST_ADR_ACKMODE, 32'h0000FFFF, "ackmode reset");
		rdChk(`SIST_ADR_SUPPLY, 32'h00000000, "supply reset");
		rdChk(`SIST_ADR_PAIR, 32'h00000000, "pair reset");
		rdChk(`SIST_ADR_FLT_LO, 32'h006DB6DB, "filter lo reset");
		rdChk(`SIST_ADR_FLT_HI, 32'h006DB6DB, "filter hi reset");
		rdChk(8'h3C, 32'h00000000, "unmapped read");
		seen = 1'h0;
		repeat (1100) begin
			@(posedge clk);
			if (sensorSupplyA !== 1'h1 || sensorSupplyB !== 1'h1) seen = 1'h1;
		end
		chk(seen, 0, "pulse while test off");
		$display("Test defaults done");
		ctl = 32'h00000002;
		for (int i = 0; i < 8; i++) begin
			for (int d = 0; d < 4; d++) begin
				wr(`SIST_ADR_CTRL, ctrlVal(i, d));
				if (i <= 6 && i >= d) ctl = ctrlVal(i, d);
				rdChk(`SIST_ADR_CTRL, ctl, "ctrl accept");
				rdChk(`SIST_ADR_STAT, (i <= 6 && i >= d) ? 0 : 32'h10000, "refusal");
				wr(`SIST_ADR_STAT, 32'h00010000);
			end
		end
		$display("Test config done");
		wr(`SIST_ADR_FLT_LO, 32'h0);
		wr(`SIST_ADR_FLT_HI, 32'h0);
		wr(`SIST_ADR_MASK, 32'h18);
		wr(`SIST_ADR_SUPPLY, 32'hFFDF);
		internalCh <= 16'hFFDF;
		wr(`SIST_ADR_ACT, 32'hFFBF);
		wr(`SIST_ADR_ACKMODE, 32'hFFEF);
		want <= 16'h0002;
		shortCh <= 16'h0078;
		cyc(100);
		chk(pvOut, 16'h003A, "pv before test");
		wr(`SIST_ADR_CTRL, 32'h1);
		waitSup(1'h0, n);
		chk(n <= TC + 1, 1, "pulse start");
		chk(sensorSupplyB, 0, "supply b off");
		// A genuine zero right at the pulse start
		want <= 16'h0000;
		waitSup(1'h1, w);
		chk(w, 16 * TC, "pulse length");
		chk(pvOut[1], 1, "held zero");
		waitSup(1'h0, n);
		chk(n + w, 128 * TC, "pulse spacing");
		chk(passivated, 16'h0018, "passivation");
		chk(pvOut, 16'h0020, "forced zero");
		chk(irq, 1, "irq raised");
		rdChk(`SIST_ADR_STAT, 32'h18, "status events");
		shortCh <= 16'h0060;
		waitSup(1'h1, w);
		cyc(4);
		chk(passivated, 16'h0008, "auto reintegration");
		wr(`SIST_ADR_ACK, 32'h8);
		cyc(2);
		chk(passivated, 16'h0000, "acknowledged");
		wr(`SIST_ADR_MASK, 32'h0);
		cyc(2);
		chk(irq, 0, "irq masked");
		wr(`SIST_ADR_MASK, 32'h18);
		cyc(2);
		chk(irq, 1, "irq unmasked");
		wr(`SIST_ADR_STAT, 32'h18);
		cyc(2);
		chk(irq, 0, "irq cleared");
		wr(`SIST_ADR_CTRL, 32'h0);
		waitSup(1'h1, n);
		$display("Test short circuit done");
		for (int s = 0; s < 5; s++) begin
			ft = (8 << s) * TC;
			wr(`SIST_ADR_FLT_HI, 32'(s) << 3);
			g = 4 + int'($urandom % (ft - 12));
			seen = 1'h0;
			@(posedge clk) want[9] <= 1'h1;
			repeat (g) @(posedge clk);
			want[9] <= 1'h0;
			repeat (ft) begin
				@(posedge clk);
				if (pvOut[9] !== 1'h0) seen = 1'h1;
			end
			chk(seen, 0, "glitch filtered");
			want[9] <= 1'h1;
			cyc(ft - 8);
			chk(pvOut[9], 0, "filter early");
			cyc(16);
			chk(pvOut[9], 1, "filter pass");
			@(posedge clk) want[9] <= 1'h0;
			cyc(ft + 16);
		end
		$display("Test debounce done");
		wr(`SIST_ADR_FLT_HI, 32'h0);
		wr(`SIST_ADR_ACT, 32'hFFFF);
		wr(`SIST_ADR_DISC, 32'h5);
		wr(`SIST_ADR_PAIR, 32'h04);
		want <= 16'h0404;
		cyc(80);
		chk({pvOut[10], pvOut[2]}, 2'h1, "pair result");
		want[10] <= 1'h0;
		cyc(150);
		chk(passivated[2], 0, "within discrepancy");
		cyc(170);
		chk(passivated[2], 1, "discrepancy");
		chk(pvOut[2], 0, "discrepancy zero");
		chk(freezeErr, 0, "pv frozen in pulse");
		$display("Test pairing done");
		final_report();
	end

	initial begin
		#400000;
		miscompares++;
		$display("Error at %0t: run time limit", $time);
		final_report();
	end
endmodule // tb_top
`default_nettype wire
